// file: hw/cfg_bytes_defs.svh
// register offsets, field positions and reset values of the configuration bytes
// Functional notes
// R1: byte 2 bits 3..0 enable outputs 11..8, default 1; 0 forces output low/low.
// R2: byte 3 bits 2..0 select output swing; codes 001, 011, 101; 111 reserved.
// R3: byte 5 reads revision high nibble and maker low nibble; byte 6 reads part id.
// R4: byte 7 bits 4..0 set how many bytes a block read returns; 7..5 reserved.
// R5: byte count resets to 8 hex, so nine bytes 0 to 8 are returned.
// R6: host acknowledges each returned byte, then ends with not-acknowledge and stop.
// R7: reserved bits and bytes 4 and 8 read zero; writes to them do nothing.
`ifndef CFG_BYTES_DEFS_SVH
`define CFG_BYTES_DEFS_SVH

`define OFF_OUT_ENABLE_UPPER    8'h02
`define OFF_OUTPUT_SWING_SELECT 8'h03
`define OFF_SPARE_BYTE_FOUR     8'h04
`define OFF_REVISION_MAKER      8'h05
`define OFF_PART_IDENTIFIER     8'h06
`define OFF_READ_LENGTH         8'h07
`define OFF_SPARE_BYTE_EIGHT    8'h08

`define OUT_ENABLE_MSB          3
`define OUT_ENABLE_LSB          0
`define SWING_SEL_MSB           2
`define SWING_SEL_LSB           0
`define READ_LENGTH_MSB         4
`define READ_LENGTH_LSB         0

`define RST_OUT_ENABLE          4'h0f
`define RST_SWING_SEL           3'h4
`define RST_READ_LENGTH         5'h08
`define SWING_CODE_RESERVED     3'h7

`define SYNC_STAGES             2

`endif

// file: hw/cfg_bytes_pkg.sv
// types shared by the configuration byte block
package cfg_bytes_pkg;

    // bus engine states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_RX_BYTE = 3'b001,
        ST_RX_ACK  = 3'b010,
        ST_TX_BYTE = 3'b011,
        ST_TX_ACK  = 3'b100
    } bus_state_t;

    // meaning of the byte currently being received
    typedef enum logic [2:0] {
        KIND_ADDR  = 3'b000,
        KIND_CMD   = 3'b001,
        KIND_WCNT  = 3'b010,
        KIND_WDATA = 3'b011,
        KIND_TX    = 3'b100
    } rx_kind_t;

endpackage : cfg_bytes_pkg

// file: hw/pin_sync.sv
// two-flop synchroniser for one pin, frozen by the clock enable
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    input  wire logic pin_i,
    output logic      sync_o
);

    logic meta_q;
    logic sync_q;

    // first stage is read only by the second
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= RESET_LEVEL;
            sync_q <= RESET_LEVEL;
        end else if (ce_i) begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule : pin_sync

// file: hw/cfg_bytes.sv
// serial-bus slave holding configuration bytes 2 to 8 of the clock mux
`timescale 1ns/1ps
`include "cfg_bytes_defs.svh"
module cfg_bytes
    import cfg_bytes_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR    = 7'h6c,
    parameter logic [3:0] REVISION_CODE = 4'h2,  // arbitrary value
    parameter logic [3:0] MAKER_CODE    = 4'h5,  // arbitrary value
    parameter logic [7:0] PART_ID       = 8'h3c  // arbitrary value
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic [3:0]      out_enable_o,
    output logic [2:0]      swing_sel_o
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and bus conditions

    logic       scl_s;
    logic       sda_s;
    logic       scl_d_q;
    logic       sda_d_q;

    pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .ce_i   (ce_i),
        .pin_i  (scl_i),
        .sync_o (scl_s)
    );

    pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .ce_i   (ce_i),
        .pin_i  (sda_i),
        .sync_o (sda_s)
    );

    // delayed copies for edge detection, taken after the synchronisers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else if (ce_i) begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
        end
    end

    wire scl_rise  = scl_s & ~scl_d_q;
    wire scl_fall  = ~scl_s & scl_d_q;
    wire bus_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
    wire bus_stop  = scl_s & scl_d_q & ~sda_d_q & sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // engine state

    bus_state_t state_q;
    rx_kind_t   kind_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic [5:0] tx_left_q;
    logic       hack_q;
    logic       sda_oe_q;

    logic [3:0] oe_q;
    logic [2:0] swing_q;
    logic [4:0] len_q;

    wire byte_done = (state_q == ST_RX_BYTE) && scl_fall && (bit_q == 4'd8);
    wire addr_hit  = (shift_q[7:1] == SLAVE_ADDR);
    wire wr_stb    = byte_done && (kind_q == KIND_WDATA);
    wire [7:0] count_byte = {3'b000, len_q};                              // [R5]
    wire [5:0] tx_total   = {1'b0, len_q} + 6'd1;                         // [R4]

    ////////////////////////////////////////////////////////////////////////////
    // read multiplexer; unmapped and reserved bytes read zero

    wire [7:0] rd_oe    = {4'h0, oe_q};                                   // [R7]
    wire [7:0] rd_swing = {5'h00, swing_q};                               // [R7]
    wire [7:0] rd_byte  =
        (ptr_q == `OFF_OUT_ENABLE_UPPER)    ? rd_oe :
        (ptr_q == `OFF_OUTPUT_SWING_SELECT) ? rd_swing :
        (ptr_q == `OFF_REVISION_MAKER)      ? {REVISION_CODE, MAKER_CODE} : // [R3]
        (ptr_q == `OFF_PART_IDENTIFIER)     ? PART_ID :                    // [R3]
        (ptr_q == `OFF_READ_LENGTH)         ? count_byte :
                                              8'h00;                       // [R7]

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers; writes to reserved bits and bytes are dropped

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            oe_q    <= `RST_OUT_ENABLE;                                   // [R1]
            swing_q <= `RST_SWING_SEL;
            len_q   <= `RST_READ_LENGTH;                                  // [R5]
        end else if (ce_i && wr_stb) begin
            if (ptr_q == `OFF_OUT_ENABLE_UPPER) begin
                oe_q <= shift_q[`OUT_ENABLE_MSB:`OUT_ENABLE_LSB];         // [R1]
            end else if (ptr_q == `OFF_OUTPUT_SWING_SELECT) begin
                // the reserved code would give an undefined swing, so it is refused
                if (shift_q[`SWING_SEL_MSB:`SWING_SEL_LSB] != `SWING_CODE_RESERVED) begin
                    swing_q <= shift_q[`SWING_SEL_MSB:`SWING_SEL_LSB];    // [R2]
                end
            end else if (ptr_q == `OFF_READ_LENGTH) begin
                len_q <= shift_q[`READ_LENGTH_MSB:`READ_LENGTH_LSB];      // [R4]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit engine: sda changes only after scl falls, samples on scl rise

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q   <= ST_IDLE;
            kind_q    <= KIND_ADDR;
            bit_q     <= 4'd0;
            shift_q   <= 8'h00;
            ptr_q     <= 8'h00;
            tx_left_q <= 6'd0;
            hack_q    <= 1'b0;
            sda_oe_q  <= 1'b0;
        end else if (ce_i) begin
            if (bus_stop) begin
                state_q  <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end else if (bus_start) begin
                // repeated start keeps the pointer for the read that follows
                state_q  <= ST_RX_BYTE;
                kind_q   <= KIND_ADDR;
                bit_q    <= 4'd0;
                sda_oe_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_RX_BYTE: begin
                        if (scl_rise && bit_q != 4'd8) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_q   <= bit_q + 4'd1;
                        end else if (byte_done) begin
                            if (kind_q == KIND_ADDR && !addr_hit) begin
                                state_q <= ST_IDLE;  // not ours, stay off the bus
                            end else begin
                                state_q  <= ST_RX_ACK;
                                sda_oe_q <= 1'b1;
                                if (kind_q == KIND_ADDR) begin
                                    kind_q <= shift_q[0] ? KIND_TX : KIND_CMD;
                                end else if (kind_q == KIND_CMD) begin
                                    ptr_q  <= shift_q;
                                    kind_q <= KIND_WCNT;
                                end else if (kind_q == KIND_WCNT) begin
                                    kind_q <= KIND_WDATA;
                                end else begin
                                    ptr_q <= ptr_q + 8'd1;
                                end
                            end
                        end
                    end
                    ST_RX_ACK: begin
                        if (scl_fall) begin
                            bit_q <= 4'd0;
                            if (kind_q == KIND_TX) begin
                                shift_q   <= count_byte;                  // [R5]
                                sda_oe_q  <= ~count_byte[7];
                                tx_left_q <= tx_total;                    // [R4]
                                state_q   <= ST_TX_BYTE;
                            end else begin
                                sda_oe_q <= 1'b0;
                                state_q  <= ST_RX_BYTE;
                            end
                        end
                    end
                    ST_TX_BYTE: begin
                        if (scl_fall) begin
                            if (bit_q == 4'd7) begin
                                sda_oe_q <= 1'b0;
                                state_q  <= ST_TX_ACK;
                            end else begin
                                shift_q  <= {shift_q[6:0], 1'b1};
                                sda_oe_q <= ~shift_q[6];
                                bit_q    <= bit_q + 4'd1;
                            end
                        end
                    end
                    ST_TX_ACK: begin
                        if (scl_rise) begin
                            hack_q <= ~sda_s;
                        end else if (scl_fall) begin
                            bit_q <= 4'd0;
                            // a not-acknowledge ends the read; the stop follows
                            if (!hack_q) begin
                                state_q <= ST_IDLE;                       // [R6]
                            end else if (tx_left_q == 6'd0) begin
                                // past the byte count the line is left released
                                shift_q <= 8'hff;                         // [R4]
                                state_q <= ST_TX_BYTE;
                            end else begin
                                shift_q   <= rd_byte;
                                sda_oe_q  <= ~rd_byte[7];
                                ptr_q     <= ptr_q + 8'd1;
                                tx_left_q <= tx_left_q - 6'd1;            // [R4]
                                state_q   <= ST_TX_BYTE;
                            end
                        end
                    end
                    default: begin
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // open-drain: the pin is only ever pulled low
    assign sda_o        = 1'b0;
    assign sda_oe_o     = sda_oe_q;
    assign out_enable_o = oe_q;                                           // [R1]
    assign swing_sel_o  = swing_q;                                        // [R2]

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    AST_OE_WRITE: assert property (ce_i && wr_stb && ptr_q == `OFF_OUT_ENABLE_UPPER |=> // [R1]
        out_enable_o == $past(shift_q[3:0])) else $error("output enable write lost");
    AST_SWING_NEVER_RESERVED: assert property (swing_sel_o != 3'h7) // [R2]
        else $error("reserved swing code applied");
    AST_SWING_REFUSE: assert property (wr_stb && shift_q[2:0] == 3'h7 |=> $stable(swing_sel_o)) // [R2]
        else $error("reserved swing code accepted");
    AST_ID_BYTES: assert property ((ptr_q == 8'h05 |-> rd_byte == {REVISION_CODE, MAKER_CODE}) and // [R3]
        (ptr_q == 8'h06 |-> rd_byte == PART_ID)) else $error("identity byte wrong");
    AST_LEN_WRITE: assert property (ce_i && wr_stb && ptr_q == `OFF_READ_LENGTH |=> // [R4]
        len_q == $past(shift_q[4:0])) else $error("read length write lost");
    AST_COUNT_SENT: assert property (ce_i && state_q == ST_RX_ACK && kind_q == KIND_TX && scl_fall |=> // [R5]
        shift_q == {3'b000, len_q} && tx_left_q == len_q + 5'd1) else $error("count byte wrong");
    AST_NACK_RELEASE: assert property (ce_i && state_q == ST_TX_ACK && scl_fall && !hack_q && !bus_stop // [R6]
        && !bus_start |=> state_q == ST_IDLE ##1 !sda_oe_o) else $error("no release after nack");
    AST_RESERVED_ZERO: assert property ((ptr_q == 8'h04 || ptr_q == 8'h08) |-> rd_byte == 8'h00) // [R7]
        else $error("reserved byte not zero");
    AST_STOP_IDLE: assert property (ce_i && bus_stop |=> state_q == ST_IDLE && !sda_oe_o [*2]) // [R6]
        else $error("stop did not free the bus");

endmodule : cfg_bytes

// file: bench/smbus_host_model.sv
// behavioural two-wire host that frames writes and reads toward the config bytes
`timescale 1ns/1ps
module smbus_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // scl starts driven high and sda starts released, so the pull-up holds sda high
    initial begin
        scl_o     <= 1'b1;
        sda_low_o <= 1'b0;
    end
    // five clocks a phase keeps every scl level above the four the slave needs
    task automatic half();
        repeat (5) @(posedge clk_i);
    endtask : half
    // also serves as repeated start, since scl is low on entry mid-frame
    task automatic start();
        sda_low_o <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        sda_low_o <= 1'b1;
        half();
        scl_o <= 1'b0;
        half();
    endtask : start
    task automatic stop();
        sda_low_o <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        sda_low_o <= 1'b0;
        half();
    endtask : stop
    // data changes only while scl is low and is sampled late in the high phase
    task automatic xfer_bit(input logic b, output logic r);
        sda_low_o <= ~b;
        half();
        scl_o <= 1'b1;
        half();
        r = sda_i;
        scl_o <= 1'b0;
        half();
    endtask : xfer_bit
    // ack_in low acknowledges a returned byte, high leaves it unacknowledged
    task automatic xfer_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_o);
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], q[i]);
        end
        xfer_bit(ack_in, ack_o);
    endtask : xfer_byte
endmodule : smbus_host_model

// file: bench/clock_mux_smbus_config_bytes_tb_top.sv
// self-checking bench for the configuration byte block
`timescale 1ns/1ps
module clock_mux_smbus_config_bytes_tb_top;
    localparam logic [3:0] REV   = 4'h9;   // arbitrary value
    localparam logic [3:0] MAKER = 4'h6;   // arbitrary value
    localparam logic [7:0] PART  = 8'h5a;  // arbitrary value
    logic       clk_i;
    logic       nrst_i;
    logic       ce_i;
    logic       scl;
    logic       sda_low;
    logic       sda_o;
    logic       sda_oe_o;
    logic [3:0] out_enable_o;
    logic [2:0] swing_sel_o;
    logic [7:0] rbuf [0:15];
    logic [7:0] rcnt;
    int         fails   = 0;
    int         n_tests = 0;
    int         cycles  = 0;
    wire logic  sda_line;
    // open-drain wire: whichever party pulls low wins over the pull-up
    assign sda_line = ~(sda_low | (sda_oe_o & ~sda_o));
    cfg_bytes #(.SLAVE_ADDR(7'h6c), .REVISION_CODE(REV), .MAKER_CODE(MAKER), .PART_ID(PART)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .out_enable_o(out_enable_o), .swing_sel_o(swing_sel_o));
    smbus_host_model host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // hang guard, well above the roughly 17800 cycles (about 1200 bit times) the scenarios need
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one-byte write frame to any address; the count byte is sent as 1 and ignored by the slave
    task automatic frame(input logic [7:0] addr, input logic [7:0] off, input logic [7:0] data,
                         output logic a_addr, output logic a_data);
        logic [7:0] q;
        logic       a;
        host.start();
        host.xfer_byte(addr, 1'b1, q, a_addr);
        host.xfer_byte(off, 1'b1, q, a);
        host.xfer_byte(8'h01, 1'b1, q, a);
        host.xfer_byte(data, 1'b1, q, a_data);
        host.stop();
    endtask : frame
    task automatic wr(input logic [7:0] off, input logic [7:0] data);
        logic aa;
        logic ad;
        frame(8'hd8, off, data, aa, ad);
        chk("addr ack", 8'h00, {7'h0, aa});
        chk("data ack", 8'h00, {7'h0, ad});
    endtask : wr
    // block read of n bytes from off; count byte lands in rcnt
    task automatic rd(input logic [7:0] off, input int n);
        logic a;
        host.start();
        host.xfer_byte(8'hd8, 1'b1, rcnt, a);
        host.xfer_byte(off, 1'b1, rcnt, a);
        host.start();
        host.xfer_byte(8'hd9, 1'b1, rcnt, a);
        host.xfer_byte(8'hff, 1'b0, rcnt, a);
        for (int i = 0; i < n; i++) begin
            host.xfer_byte(8'hff, (i == n - 1), rbuf[i], a);
        end
        host.stop();
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        logic [7:0] exp [0:6];
        exp = '{8'h0f, 8'h04, 8'h00, {REV, MAKER}, PART, 8'h08, 8'h00};
        chk("out_enable", 8'h0f, {4'h0, out_enable_o});
        chk("swing_sel", 8'h04, {5'h0, swing_sel_o});
        rd(8'h00, 10);
        chk("count", 8'h08, rcnt);
        for (int i = 0; i < 7; i++) begin
            chk("byte", exp[i], rbuf[i + 2]);
        end
        chk("past end", 8'hff, rbuf[9]);
    endtask : t_defaults
    // a frame for another slave address must get no ack and change nothing
    task automatic t_foreign();
        logic aa;
        logic ad;
        frame(8'hda, 8'h02, 8'h00, aa, ad);
        chk("foreign ack", 8'h01, {7'h0, aa});
        chk("out_enable", 8'h0f, {4'h0, out_enable_o});
    endtask : t_foreign
    // with the clock enable low the block is frozen: no ack, no write
    task automatic t_frozen();
        logic aa;
        logic ad;
        ce_i <= 1'b0;
        frame(8'hd8, 8'h02, 8'h00, aa, ad);
        ce_i <= 1'b1;
        chk("frozen ack", 8'h01, {7'h0, aa});
        chk("out_enable", 8'h0f, {4'h0, out_enable_o});
    endtask : t_frozen
    // clear one enable at a time, with the reserved high nibble set
    task automatic t_enables();
        logic [3:0] e;
        for (int i = 0; i < 4; i++) begin
            e = ~(4'h1 << i);
            wr(8'h02, {4'hf, e});
            chk("out_enable", {4'h0, e}, {4'h0, out_enable_o});
            rd(8'h02, 1);
            chk("byte 2", {4'h0, e}, rbuf[0]);
        end
    endtask : t_enables
    task automatic t_swing();
        logic [2:0] codes [0:2];
        codes = '{3'h1, 3'h3, 3'h5};
        for (int i = 0; i < 3; i++) begin
            wr(8'h03, {5'h1f, codes[i]});
            chk("swing_sel", {5'h0, codes[i]}, {5'h0, swing_sel_o});
            rd(8'h03, 1);
            chk("byte 3", {5'h0, codes[i]}, rbuf[0]);
        end
        wr(8'h03, 8'h07);
        chk("swing kept", 8'h05, {5'h0, swing_sel_o});
    endtask : t_swing
    // shorter block read, after writes aimed at read-only and spare bytes
    task automatic t_length();
        logic [7:0] exp [0:5];
        exp = '{8'h00, {REV, MAKER}, PART, 8'h04, 8'h00, 8'hff};
        wr(8'h07, 8'he4);
        for (int i = 4; i < 9; i++) begin
            if (i != 7) begin
                wr(i[7:0], 8'haa);
            end
        end
        rd(8'h04, 6);
        chk("count", 8'h04, rcnt);
        for (int i = 0; i < 6; i++) begin
            chk("block", exp[i], rbuf[i]);
        end
    endtask : t_length
    task automatic t_rereset();
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("out_enable", 8'h0f, {4'h0, out_enable_o});
        rd(8'h07, 1);
        chk("count", 8'h08, rcnt);
    endtask : t_rereset
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst_i <= 1'b0;
        ce_i   <= 1'b1;
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_defaults();
        t_foreign();
        t_frozen();
        t_enables();
        t_swing();
        t_length();
        t_rereset();
        close_out();
    end
endmodule : clock_mux_smbus_config_bytes_tb_top
